// *** hw/isc_defs.svh ***
/*
 Offsets, field positions, reset values and sizes for the intrusion status/control block.
 Assumes byte addressing on a 32-bit APB.
*/
`ifndef ISC_DEFS_SVH
`define ISC_DEFS_SVH
`define ISC_OFF_DATA_LO 8'h04
`define ISC_OFF_DATA_LO_END 8'h28
`define ISC_OFF_CTRL 8'h30
`define ISC_OFF_CSTS 8'h34
`define ISC_OFF_DATA_HI 8'h40
`define ISC_OFF_DATA_HI_END 8'hbc
`define ISC_NUM_WORDS 42
`define ISC_LO_WORDS 10
`define ISC_DATA_W 16
`define ISC_B_EVCLR 0
`define ISC_B_IRQCLR 1
`define ISC_B_IEN 2
`define ISC_B_EVFLG 8
`define ISC_B_IRQFLG 9
`define ISC_B_PFS 0
`define ISC_B_PAL 1
`define ISC_RST_WORD 32'h0000_0000
`endif

// *** hw/isc_pkg.sv ***
/*
 Types shared by the intrusion status/control block.
 Assumes isc_defs.svh is on the include path.
*/
`include "isc_defs.svh"
package isc_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } isc_apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } isc_apb_rsp_t;
  typedef enum logic [1:0] {ISC_IDLE, ISC_ARMED, ISC_TRIPPED} isc_det_state_t;
endpackage

// *** hw/isc_word.sv ***
/*
 One backup data word.
 Assumes the owner gates writes and raises wipe while the event flag stands.
*/
`timescale 1ns/1ps
`include "isc_defs.svh"
module isc_word (
  // Clock and reset.
  input wire logic pclk,
  input wire logic bkp_rst_n,
  // Control.
  input wire logic wipe,
  input wire logic we,
  input wire logic [`ISC_DATA_W-1:0] wdata,
  // State.
  output logic [`ISC_DATA_W-1:0] q
);
  logic [`ISC_DATA_W-1:0] word_q;
  always_ff @(posedge pclk or negedge bkp_rst_n) begin
    if (!bkp_rst_n) begin
      word_q <= '0;
    end else if (wipe) begin
      word_q <= '0;
    end else if (we) begin
      word_q <= wdata;
    end
  end
  assign q = word_q;
endmodule

// *** hw/isc_top.sv ***
/*
 Intrusion detection status/control with backup data words, APB slave.
 Assumes a synchronous intrusion pin, a system reset presetn and a backup-domain reset bkp_rst_n.
*/
// Functional notes
// [RQ1] Event clear bit: write-only, clears flag, re-arms
// [RQ2] Interrupt clear bit: write-only, drops request and flag
// [RQ3] Interrupt enable reset only by system/standby reset
// [RQ4] Intrusion request never drives a wake-up
// [RQ5] Software selects pin function before enabling interrupt
// [RQ6] Event flag set by hardware, cleared by write
// [RQ7] Intrusion clears all backup data words
// [RQ8] Flag set holds words cleared, discards writes
// [RQ9] Interrupt flag sets on enabled event, write-clears
// [RQ10] Detection only when pin function select is one
// [RQ11] Level select: zero high active, one low
// [RQ12] Pin already active at enabling gives event
// [RQ13] Reserved bits read zero, ignore writes
// [RQ14] Request on dedicated line while flag and enable
`timescale 1ns/1ps
`include "isc_defs.svh"
module isc_top (
  // Clock and resets.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic bkp_rst_n,
  // APB.
  input wire isc_pkg::isc_apb_req_t apb_req,
  output isc_pkg::isc_apb_rsp_t apb_rsp,
  // Intrusion pin.
  input wire logic intrusion_pin,
  // Interrupt and wake-up.
  output logic intrusion_irq,
  output logic intrusion_wakeup
);
  import isc_pkg::*;

  logic [31:0] prdata_q, prdata_d;
  logic pready_q;
  logic pslverr_q;
  logic pin_function_select_q;
  logic pin_active_level_select_q;
  logic intrusion_irq_enable_q;
  logic intrusion_event_flag_q;
  logic intrusion_irq_flag_q;
  logic irq_q;
  isc_det_state_t det_q, det_d;
  logic [`ISC_DATA_W-1:0] words [`ISC_NUM_WORDS];

  // The access phase takes one wait state; pready stands for one cycle only.
  wire access = apb_req.psel && apb_req.penable && pready_q;
  wire wr = access && apb_req.pwrite;
  wire [7:0] addr = apb_req.paddr;
  wire hit_ctrl = (addr == `ISC_OFF_CTRL);
  wire hit_csts = (addr == `ISC_OFF_CSTS);
  wire hit_lo = (addr >= `ISC_OFF_DATA_LO) && (addr <= `ISC_OFF_DATA_LO_END) && (addr[1:0] == 2'h0);
  wire hit_hi = (addr >= `ISC_OFF_DATA_HI) && (addr <= `ISC_OFF_DATA_HI_END) && (addr[1:0] == 2'h0);
  wire [5:0] idx_lo = 6'((addr - `ISC_OFF_DATA_LO) >> 2);
  wire [5:0] idx_hi = 6'(((addr - `ISC_OFF_DATA_HI) >> 2) + `ISC_LO_WORDS);
  wire hit_data = hit_lo || hit_hi;
  wire [5:0] widx = hit_lo ? idx_lo : idx_hi;
  wire mapped = hit_ctrl || hit_csts || hit_data;

  wire wr_csts = wr && hit_csts;
  wire ev_clr = wr_csts && apb_req.pwdata[`ISC_B_EVCLR]; // RQ1
  wire irq_clr = wr_csts && apb_req.pwdata[`ISC_B_IRQCLR]; // RQ2

  // Active level compare; detection gated by the pin function select.
  wire pin_active = pin_active_level_select_q ? !intrusion_pin : intrusion_pin; // RQ11
  wire det_on = pin_function_select_q; // RQ10

  // The detector is level sensitive once armed, so a pin already active when
  // detection is enabled raises an event; it arms on the next edge and the flag sets on the second.
  always_comb begin
    det_d = det_q;
    case (det_q)
      ISC_IDLE: begin
        if (det_on) begin
          det_d = ISC_ARMED;
        end
      end
      ISC_ARMED: begin
        if (!det_on) begin
          det_d = ISC_IDLE;
        end else if (pin_active) begin
          det_d = ISC_TRIPPED; // RQ12
        end
      end
      ISC_TRIPPED: begin
        if (ev_clr) begin
          det_d = ISC_IDLE; // RQ1
        end
      end
      default: det_d = ISC_IDLE;
    endcase
  end
  wire intrusion = (det_q == ISC_ARMED) && det_on && pin_active; // RQ10

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      det_q <= ISC_IDLE;
    end else begin
      det_q <= det_d;
    end
  end

  // Pin configuration lives in the backup domain.
  always_ff @(posedge pclk or negedge bkp_rst_n) begin
    if (!bkp_rst_n) begin
      pin_function_select_q <= 1'b0;
      pin_active_level_select_q <= 1'b0;
      intrusion_event_flag_q <= 1'b0;
    end else begin
      if (wr && hit_ctrl) begin
        pin_function_select_q <= apb_req.pwdata[`ISC_B_PFS];
        pin_active_level_select_q <= apb_req.pwdata[`ISC_B_PAL];
      end
      // A new event wins over a clear in the same cycle.
      if (intrusion) begin
        intrusion_event_flag_q <= 1'b1; // RQ6
      end else if (ev_clr) begin
        intrusion_event_flag_q <= 1'b0; // RQ1
      end
    end
  end

  // Enable and interrupt flag fall only to the system reset, which also covers standby wake-up.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      intrusion_irq_enable_q <= 1'b0; // RQ3
      intrusion_irq_flag_q <= 1'b0; // RQ9
      irq_q <= 1'b0;
      intrusion_wakeup <= 1'b0;
    end else begin
      if (wr_csts) begin
        intrusion_irq_enable_q <= apb_req.pwdata[`ISC_B_IEN];
      end
      if (intrusion && intrusion_irq_enable_q) begin
        intrusion_irq_flag_q <= 1'b1; // RQ9
      end else if (irq_clr) begin
        intrusion_irq_flag_q <= 1'b0; // RQ2
      end
      irq_q <= intrusion_irq_flag_q && intrusion_irq_enable_q && !irq_clr; // RQ14
      intrusion_wakeup <= 1'b0; // RQ4
    end
  end
  assign intrusion_irq = irq_q;

  // Backup words: wiped by an event and held wiped while the flag stands.
  wire wipe = intrusion || intrusion_event_flag_q; // RQ7 RQ8
  for (genvar i = 0; i < `ISC_NUM_WORDS; i++) begin : g_word
    isc_word u_word (
      .pclk(pclk),
      .bkp_rst_n(bkp_rst_n),
      .wipe(wipe),
      .we(wr && hit_data && (widx == 6'(i)) && !intrusion_event_flag_q), // RQ8
      .wdata(apb_req.pwdata[`ISC_DATA_W-1:0]),
      .q(words[i])
    );
  end

  // Clear bits and reserved bits read as zero.
  always_comb begin
    prdata_d = `ISC_RST_WORD; // RQ13
    if (hit_csts) begin
      prdata_d[`ISC_B_IEN] = intrusion_irq_enable_q;
      prdata_d[`ISC_B_EVFLG] = intrusion_event_flag_q; // RQ6
      prdata_d[`ISC_B_IRQFLG] = intrusion_irq_flag_q;
    end else if (hit_ctrl) begin
      prdata_d[`ISC_B_PFS] = pin_function_select_q;
      prdata_d[`ISC_B_PAL] = pin_active_level_select_q;
    end else if (hit_data) begin
      prdata_d[`ISC_DATA_W-1:0] = words[widx];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= `ISC_RST_WORD;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= apb_req.psel && apb_req.penable && !pready_q;
      prdata_q <= prdata_d;
      pslverr_q <= apb_req.psel && apb_req.penable && !pready_q && !mapped;
    end
  end
  assign apb_rsp.pready = pready_q;
  assign apb_rsp.prdata = prdata_q;
  assign apb_rsp.pslverr = pslverr_q;

  property p_event_sets_flags;
    @(posedge pclk) disable iff (!presetn)
      intrusion |=> intrusion_event_flag_q && (det_q == ISC_TRIPPED);
  endproperty
  a_event_sets_flags: assert property (p_event_sets_flags) else $error("event flag not set"); // RQ6

  property p_evclr;
    @(posedge pclk) disable iff (!presetn)
      ev_clr && !intrusion |=> !intrusion_event_flag_q;
  endproperty
  a_evclr: assert property (p_evclr) else $error("event clear failed"); // RQ1

  property p_irqflag;
    @(posedge pclk) disable iff (!presetn)
      intrusion && intrusion_irq_enable_q |=> intrusion_irq_flag_q ##1 (intrusion_irq || $past(irq_clr));
  endproperty
  a_irqflag: assert property (p_irqflag) else $error("irq flag or request missing"); // RQ9

  property p_irqclr;
    @(posedge pclk) disable iff (!presetn)
      irq_clr && !intrusion |=> !intrusion_irq && !intrusion_irq_flag_q;
  endproperty
  a_irqclr: assert property (p_irqclr) else $error("irq clear failed"); // RQ2

  property p_wipe;
    @(posedge pclk) disable iff (!presetn || !bkp_rst_n)
      intrusion |=> (words[0] == '0) && (words[`ISC_NUM_WORDS-1] == '0);
  endproperty
  a_wipe: assert property (p_wipe) else $error("words not wiped"); // RQ7

  property p_hold;
    @(posedge pclk) disable iff (!presetn || !bkp_rst_n)
      intrusion_event_flag_q |=> (words[0] == '0) && (words[`ISC_LO_WORDS-1] == '0);
  endproperty
  a_hold: assert property (p_hold) else $error("write landed while flag set"); // RQ8

  property p_gpio;
    @(posedge pclk) disable iff (!presetn || !bkp_rst_n)
      !pin_function_select_q && !intrusion_event_flag_q |=> !intrusion_event_flag_q;
  endproperty
  a_gpio: assert property (p_gpio) else $error("event while detection off"); // RQ10

  sequence s_armed_active;
    (det_q == ISC_ARMED) && pin_function_select_q && (intrusion_pin != pin_active_level_select_q);
  endsequence
  property p_level;
    @(posedge pclk) disable iff (!presetn)
      s_armed_active |=> intrusion_event_flag_q;
  endproperty
  a_level: assert property (p_level) else $error("active level missed"); // RQ11

  property p_nowake;
    @(posedge pclk) disable iff (!presetn)
      intrusion_irq |-> !intrusion_wakeup;
  endproperty
  a_nowake: assert property (p_nowake) else $error("wake-up driven"); // RQ4

  property p_rsvd;
    @(posedge pclk) disable iff (!presetn)
      pready_q && hit_csts |-> (prdata_q[31:10] == '0) && (prdata_q[7:3] == '0) && (prdata_q[1:0] == '0);
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero"); // RQ13
endmodule

// *** verification/isc_sensor.sv ***
/*
 Model of the external intrusion sensing line.
 Assumes the bench sets the wanted pin level just after a rising edge.
*/
`timescale 1ns/1ps
module isc_sensor (
  // Clock.
  input wire logic pclk,
  // Wanted level from the bench.
  input wire logic level,
  // Pin into the block.
  output logic intrusion_pin
);
  // The line is retimed so the block sees a synchronous level, as it expects.
  always_ff @(posedge pclk) begin
    intrusion_pin <= level;
  end
endmodule

// *** verification/tb_intrusion_status_control.sv ***
/*
 Self-checking bench for the intrusion status/control block.
 Assumes isc_pkg, isc_defs.svh, isc_top and isc_sensor are compiled before it.
*/
`timescale 1ns/1ps
`include "isc_defs.svh"
module tb_intrusion_status_control;
  import isc_pkg::*;
  logic pclk, presetn, bkp_rst_n, level, intrusion_pin, intrusion_irq, intrusion_wakeup, se;
  isc_apb_req_t apb_req;
  isc_apb_rsp_t apb_rsp;
  logic [31:0] rd;
  int err_total, tests_run;

  isc_top i_isc_top (.pclk(pclk), .presetn(presetn), .bkp_rst_n(bkp_rst_n), .apb_req(apb_req),
    .apb_rsp(apb_rsp), .intrusion_pin(intrusion_pin), .intrusion_irq(intrusion_irq),
    .intrusion_wakeup(intrusion_wakeup));
  isc_sensor i_isc_sensor (.pclk(pclk), .level(level), .intrusion_pin(intrusion_pin));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer; the request stands until pready is seen high.
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    apb_req <= '{1'b1, 1'b0, wr, a, d};
    @(posedge pclk);
    apb_req.penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (apb_rsp.pready !== 1'b1 && n < 50);
    rd = apb_rsp.prdata;
    se = apb_rsp.pslverr;
    apb_req <= '0;
    if (n >= 50) chk(32'h0, 32'h1);
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  task set_level(input logic v);
    @(posedge pclk);
    level <= v;
    repeat (5) @(posedge pclk);
  endtask

  task t_reset;
    rdc(`ISC_OFF_CSTS, `ISC_RST_WORD);
    rdc(`ISC_OFF_CTRL, 32'h0);
  endtask

  task t_map;
    apb(1'b1, `ISC_OFF_DATA_HI_END, 32'habcd_1234);
    rdc(`ISC_OFF_DATA_HI_END, 32'h0000_1234);
    rdc(8'h2c, 32'h0);
    chk({31'h0, se}, 32'h1);
  endtask

  task t_gpio;
    apb(1'b1, `ISC_OFF_DATA_LO, 32'h0000_00a5);
    set_level(1'b1);
    rdc(`ISC_OFF_CSTS, 32'h0);
    apb(1'b1, `ISC_OFF_CTRL, 32'h1);
    repeat (4) @(posedge pclk);
    rdc(`ISC_OFF_CSTS, 32'h0000_0100);
    rdc(`ISC_OFF_DATA_LO, 32'h0);
    apb(1'b1, `ISC_OFF_DATA_LO_END, 32'h0000_7777);
    rdc(`ISC_OFF_DATA_LO_END, 32'h0);
    set_level(1'b0);
    apb(1'b1, `ISC_OFF_CSTS, 32'h1);
    rdc(`ISC_OFF_CSTS, 32'h0);
    apb(1'b1, `ISC_OFF_DATA_LO, 32'h0000_0055);
    rdc(`ISC_OFF_DATA_LO, 32'h0000_0055);
  endtask

  task t_irq;
    apb(1'b1, `ISC_OFF_CSTS, 32'h4);
    apb(1'b1, `ISC_OFF_CSTS, 32'hffff_fcfc);
    rdc(`ISC_OFF_CSTS, 32'h0000_0004);
    set_level(1'b1);
    chk({31'h0, intrusion_irq}, 32'h1);
    chk({31'h0, intrusion_wakeup}, 32'h0);
    rdc(`ISC_OFF_CSTS, 32'h0000_0304);
    apb(1'b1, `ISC_OFF_CSTS, 32'h6);
    rdc(`ISC_OFF_CSTS, 32'h0000_0104);
    chk({31'h0, intrusion_irq}, 32'h0);
    set_level(1'b0);
    apb(1'b1, `ISC_OFF_CSTS, 32'h5);
    rdc(`ISC_OFF_CSTS, 32'h0000_0004);
  endtask

  task t_level;
    apb(1'b1, `ISC_OFF_CTRL, 32'h0);
    apb(1'b1, `ISC_OFF_CTRL, 32'h2);
    set_level(1'b1);
    apb(1'b1, `ISC_OFF_CTRL, 32'h3);
    repeat (4) @(posedge pclk);
    rdc(`ISC_OFF_CSTS, 32'h0000_0004);
    set_level(1'b0);
    rdc(`ISC_OFF_CSTS, 32'h0000_0304);
    set_level(1'b1);
    apb(1'b1, `ISC_OFF_CSTS, 32'h7);
    rdc(`ISC_OFF_CSTS, 32'h0000_0004);
  endtask

  task t_resets;
    @(posedge pclk);
    bkp_rst_n <= 1'b0;
    repeat (2) @(posedge pclk);
    bkp_rst_n <= 1'b1;
    rdc(`ISC_OFF_CSTS, 32'h0000_0004);
    rdc(`ISC_OFF_CTRL, 32'h0);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rdc(`ISC_OFF_CSTS, 32'h0);
  endtask

  task results;
    if (err_total == 0 && tests_run > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end

  initial begin
    #1000000;
    err_total++;
    results;
  end

  initial begin
    presetn = 1'b0;
    bkp_rst_n = 1'b0;
    level = 1'b0;
    apb_req = '0;
    err_total = 0;
    tests_run = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    bkp_rst_n <= 1'b1;
    t_reset;
    t_map;
    t_gpio;
    t_irq;
    t_level;
    t_resets;
    results;
  end
endmodule
